//--- fpa_add_unit.v
// Fixed-point add datapath: upper-immediate add, add-to-minus-one and
// add-to-zero extended, add-immediate-carrying-with-record.
// Assumes decode presents an instruction with its source operand in the
// same cycle, and the register file reads the source index combinationally.
//
// Behaviour
// - Upper add: source plus immediate shifted sixteen
// - Upper add: source index zero gives zero operand
// - Upper add leaves all flags unchanged
// - Wide mode sign-extends upper add result
// - Upper add decoded by opcode fifteen
// - Minus-one add: source plus carry plus ones
// - Minus-one add: opcode 31, extended 234
// - Zero add: source plus carry plus zero
// - Zero add: opcode 31, extended 202
// - Extended adds always update the carry
// - Overflow enable updates wrap and sticky
// - Record bit updates condition field zero
// - Immediate record add updates carry, field
// - Immediate record add sign-extends immediate
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "fpa_consts.vh"

module fpa_add_unit #(
    parameter W = 64,
    parameter H = 32
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire         issue_valid,
    input  wire [31:0]  issue_instr,
    output wire [4:0]   src_index,
    input  wire [W-1:0] src_data,
    output reg          wb_valid,
    output reg  [4:0]   wb_index,
    output reg  [W-1:0] wb_data,
    output wire         add_out_bit,
    output wire         signed_wrap_flag,
    output wire         sticky_wrap_flag,
    output wire [3:0]   cond_field0,
    output wire         irq,
    input  wire [7:0]   bus_addr,
    input  wire [31:0]  bus_wdata,
    input  wire         bus_wr,
    input  wire         bus_rd,
    output reg  [31:0]  bus_rdata
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function [3:0] cr_of;
        input [W-1:0] v;
        input         wide;
        input         so;
        reg           neg;
        reg           zer;
        begin
            neg = wide ? v[W-1] : v[H-1];
            zer = wide ? (v == {W{1'b0}}) : (v[H-1:0] == {H{1'b0}});
            // One-hot among below, above and zero
            cr_of = {neg, !neg && !zer, zer, so};
        end
    endfunction

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg          ca_r;
    reg          ov_r;
    reg          so_r;
    reg  [3:0]   cr_r;
    reg          mode64_r;
    reg  [3:0]   ev_r;
    reg  [3:0]   mask_r;
    reg  [W-1:0] last_r;
    reg          ca_nxt;
    reg          ov_nxt;
    reg          so_nxt;
    reg  [3:0]   cr_nxt;
    reg  [W-1:0] op_a;
    reg  [W-1:0] op_b;
    reg          op_cin;
    reg          upd_ca;
    reg          upd_ov;
    reg          upd_cr;
    reg  [3:0]   ev_set;
    reg  [31:0]  rd_nxt;

    wire         is_upper;
    wire         is_minus1;
    wire         is_zero;
    wire         is_immrec;
    wire         is_bad;
    wire [4:0]   dst;
    wire [4:0]   src;
    wire [15:0]  imm;
    wire         oe;
    wire         rc;
    wire [W-1:0] sum;
    wire         cout;
    wire         ovf;
    wire [W-1:0] imm_sx;
    wire [W-1:0] imm_hi;
    wire [W-1:0] res;
    wire         sel_flags;
    wire         sel_ctrl;
    wire         sel_istat;
    wire         sel_imask;
    wire         go;

    // ****************************************************************
    // Decode and operand selection
    // ****************************************************************
    fpa_decode u_dec (
        .instr     (issue_instr),
        .is_upper  (is_upper),
        .is_minus1 (is_minus1),
        .is_zero   (is_zero),
        .is_immrec (is_immrec),
        .is_bad    (is_bad),
        .dst       (dst),
        .src       (src),
        .imm       (imm),
        .oe        (oe),
        .rc        (rc)
    );

    assign src_index = src;
    assign go        = issue_valid && !is_bad;
    assign imm_sx    = {{(W-16){imm[15]}}, imm};
    // Upper form: immediate over sixteen zeros, extended from bit 31
    assign imm_hi    = {{(W-32){imm[15]}}, imm, 16'h0000};

    always @* begin
        op_a   = src_data;
        op_b   = {W{1'b0}};
        op_cin = 1'b0;
        upd_ca = 1'b0;
        upd_ov = 1'b0;
        upd_cr = 1'b0;
        if (is_upper) begin
            op_a = (src == 5'h00) ? {W{1'b0}} : src_data;
            op_b = imm_hi;
        end else if (is_minus1) begin
            op_b   = {W{1'b1}};
            op_cin = ca_r;
            upd_ca = 1'b1;
            upd_ov = oe;
            upd_cr = rc;
        end else if (is_zero) begin
            op_b   = {W{1'b0}};
            op_cin = ca_r;
            upd_ca = 1'b1;
            upd_ov = oe;
            upd_cr = rc;
        end else if (is_immrec) begin
            op_b   = imm_sx;
            upd_ca = 1'b1;
            upd_cr = 1'b1;
        end
    end

    fpa_adder #(
        .W (W),
        .H (H)
    ) u_add (
        .a    (op_a),
        .b    (op_b),
        .cin  (op_cin),
        .wide (mode64_r),
        .sum  (sum),
        .cout (cout),
        .ovf  (ovf)
    );

    // ****************************************************************
    // Flag update
    // ****************************************************************
    // Upper form never raises an update term, so all flags hold there
    always @* begin
        ca_nxt = ca_r;
        ov_nxt = ov_r;
        so_nxt = so_r;
        cr_nxt = cr_r;
        if (bus_wr && sel_flags) begin
            ca_nxt = bus_wdata[`FPA_B_CA];
            ov_nxt = bus_wdata[`FPA_B_OV];
            so_nxt = bus_wdata[`FPA_B_SO];
            cr_nxt = bus_wdata[`FPA_B_CR_HI:`FPA_B_CR_LO];
        end
        if (go) begin
            if (upd_ca) begin
                ca_nxt = cout;
            end
            if (upd_ov) begin
                ov_nxt = ovf;
                so_nxt = so_nxt | ovf;
            end
            if (upd_cr) begin
                cr_nxt = cr_of(sum, mode64_r, so_nxt);
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ca_r <= `FPA_RST_FLAGS;
            ov_r <= `FPA_RST_FLAGS;
            so_r <= `FPA_RST_FLAGS;
            cr_r <= `FPA_RST_CR;
        end else begin
            ca_r <= ca_nxt;
            ov_r <= ov_nxt;
            so_r <= so_nxt;
            cr_r <= cr_nxt;
        end
    end

    // Wide upper form replicates result bit 31 through the upper half
    assign res = (is_upper && mode64_r) ?
                 {{(W-32){sum[31]}}, sum[31:0]} : sum;

    assign add_out_bit      = ca_r;
    assign signed_wrap_flag = ov_r;
    assign sticky_wrap_flag = so_r;
    assign cond_field0      = cr_r;

    // ****************************************************************
    // Result write-back
    // ****************************************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_valid <= 1'b0;
            wb_index <= 5'h00;
            wb_data  <= {W{1'b0}};
            last_r   <= {W{1'b0}};
        end else begin
            wb_valid <= go;
            if (go) begin
                wb_index <= dst;
                wb_data  <= res;
                last_r   <= res;
            end
        end
    end

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    always @* begin
        ev_set = 4'h0;
        ev_set[`FPA_EV_OV]  = go && upd_ov && ovf;
        ev_set[`FPA_EV_CA]  = go && upd_ca && cout;
        ev_set[`FPA_EV_BAD] = issue_valid && is_bad;
        ev_set[`FPA_EV_W]   = go;
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ev_r <= `FPA_RST_EV;
        end else if (bus_wr && sel_istat) begin
            // Set wins over a same-cycle clear
            ev_r <= (ev_r & ~bus_wdata[3:0]) | ev_set;
        end else begin
            ev_r <= ev_r | ev_set;
        end
    end

    assign irq = |(ev_r & mask_r);

    // ****************************************************************
    // Register port
    // ****************************************************************
    assign sel_flags = hit(bus_addr, `FPA_A_FLAGS);
    assign sel_ctrl  = hit(bus_addr, `FPA_A_CTRL);
    assign sel_istat = hit(bus_addr, `FPA_A_ISTAT);
    assign sel_imask = hit(bus_addr, `FPA_A_IMASK);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode64_r <= `FPA_RST_MODE64;
            mask_r   <= `FPA_RST_EV;
        end else if (bus_wr) begin
            if (sel_ctrl) begin
                mode64_r <= bus_wdata[`FPA_B_MODE64];
            end
            if (sel_imask) begin
                mask_r <= bus_wdata[3:0];
            end
        end
    end

    always @* begin
        rd_nxt = 32'h00000000;
        case (bus_addr)
            `FPA_A_FLAGS: begin
                rd_nxt[`FPA_B_CA] = ca_r;
                rd_nxt[`FPA_B_OV] = ov_r;
                rd_nxt[`FPA_B_SO] = so_r;
                rd_nxt[`FPA_B_CR_HI:`FPA_B_CR_LO] = cr_r;
            end
            `FPA_A_CTRL: begin
                rd_nxt[`FPA_B_MODE64] = mode64_r;
            end
            `FPA_A_ISTAT: begin
                rd_nxt[3:0] = ev_r;
            end
            `FPA_A_IMASK: begin
                rd_nxt[3:0] = mask_r;
            end
            `FPA_A_RES_LO: begin
                rd_nxt = last_r[31:0];
            end
            `FPA_A_RES_HI: begin
                rd_nxt = last_r[W-1:W-32];
            end
            default: begin
                rd_nxt = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= 32'h00000000;
        end else if (bus_rd) begin
            bus_rdata <= rd_nxt;
        end else begin
            bus_rdata <= 32'h00000000;
        end
    end

endmodule // fpa_add_unit
`default_nettype wire

//--- fpa_consts.vh
// Constants of the fixed-point add datapath: encodings, fields, offsets.
// Assumes the includer uses 32-bit instruction words, bit 0 as the LSB.
`ifndef FPA_CONSTS_VH
`define FPA_CONSTS_VH

// ****************************************************************
// Instruction encodings
// ****************************************************************
`define FPA_OP_UPPER      6'h0f
`define FPA_OP_IMMREC     6'h0d
`define FPA_OP_EXT        6'h1f
`define FPA_XO_MINUS1     9'h0ea
`define FPA_XO_ZERO       9'h0ca

// ****************************************************************
// Field positions, little-endian indices of the instruction word
// ****************************************************************
`define FPA_F_OP_HI       31
`define FPA_F_OP_LO       26
`define FPA_F_DST_HI      25
`define FPA_F_DST_LO      21
`define FPA_F_SRC_HI      20
`define FPA_F_SRC_LO      16
`define FPA_F_IMM_HI      15
`define FPA_F_IMM_LO      0
`define FPA_F_OE          10
`define FPA_F_XO_HI       9
`define FPA_F_XO_LO       1
`define FPA_F_RC          0

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define FPA_A_FLAGS       8'h00
`define FPA_A_CTRL        8'h04
`define FPA_A_ISTAT       8'h08
`define FPA_A_IMASK       8'h0c
`define FPA_A_RES_LO      8'h10
`define FPA_A_RES_HI      8'h14

// ****************************************************************
// Flag, control and event register bit layouts and reset values
// ****************************************************************
`define FPA_B_CA          0
`define FPA_B_OV          1
`define FPA_B_SO          2
`define FPA_B_CR_LO       4
`define FPA_B_CR_HI       7
`define FPA_B_MODE64      0
`define FPA_EV_OV         0
`define FPA_EV_CA         1
`define FPA_EV_BAD        2
`define FPA_EV_W          3
`define FPA_RST_FLAGS     1'b0
`define FPA_RST_CR        4'h0
`define FPA_RST_MODE64    1'b1
`define FPA_RST_EV        4'h0

`endif

//--- fpa_decode.v
// Instruction decode of the fixed-point add family.
// Assumes a 32-bit instruction word with little-endian bit numbering.
`timescale 1ns/1ns
`default_nettype none
`include "fpa_consts.vh"

module fpa_decode (
    input  wire [31:0] instr,
    output wire        is_upper,
    output wire        is_minus1,
    output wire        is_zero,
    output wire        is_immrec,
    output wire        is_bad,
    output wire [4:0]  dst,
    output wire [4:0]  src,
    output wire [15:0] imm,
    output wire        oe,
    output wire        rc
);
    wire [5:0] op;
    wire [8:0] xo;

    assign op        = instr[`FPA_F_OP_HI:`FPA_F_OP_LO];
    assign xo        = instr[`FPA_F_XO_HI:`FPA_F_XO_LO];
    assign dst       = instr[`FPA_F_DST_HI:`FPA_F_DST_LO];
    assign src       = instr[`FPA_F_SRC_HI:`FPA_F_SRC_LO];
    assign imm       = instr[`FPA_F_IMM_HI:`FPA_F_IMM_LO];
    assign oe        = instr[`FPA_F_OE];
    assign rc        = instr[`FPA_F_RC];
    assign is_upper  = (op == `FPA_OP_UPPER);
    assign is_immrec = (op == `FPA_OP_IMMREC);
    assign is_minus1 = (op == `FPA_OP_EXT) && (xo == `FPA_XO_MINUS1);
    assign is_zero   = (op == `FPA_OP_EXT) && (xo == `FPA_XO_ZERO);
    assign is_bad    = !(is_upper || is_immrec || is_minus1 || is_zero);
endmodule // fpa_decode
`default_nettype wire

//--- fpa_adder.v
// Two-width adder with carry-in, carry-out and signed overflow.
// Assumes operands already extended to the full width W.
`timescale 1ns/1ns
`default_nettype none

module fpa_adder #(
    parameter W = 64,
    parameter H = 32
) (
    input  wire [W-1:0] a,
    input  wire [W-1:0] b,
    input  wire         cin,
    input  wire         wide,
    output wire [W-1:0] sum,
    output wire         cout,
    output wire         ovf
);
    wire [W:0] full;
    wire [H:0] half;
    wire       sa;
    wire       sb;
    wire       ss;

    assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    assign half = {1'b0, a[H-1:0]} + {1'b0, b[H-1:0]} + {{H{1'b0}}, cin};
    // Narrow mode keeps the upper half at zero
    assign sum  = wide ? full[W-1:0] : {{(W-H){1'b0}}, half[H-1:0]};
    assign cout = wide ? full[W] : half[H];
    assign sa   = wide ? a[W-1] : a[H-1];
    assign sb   = wide ? b[W-1] : b[H-1];
    assign ss   = wide ? full[W-1] : half[H-1];
    assign ovf  = (sa == sb) && (ss != sa);
endmodule // fpa_adder
`default_nettype wire

//--- fpa_add_unit_monitor.sv
// Checker of the fixed-point add datapath, bound to its top module.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module fpa_add_unit_monitor #(
    parameter W = 64
) (
    input wire logic         clk,
    input wire logic         arst_n,
    input wire logic         issue_valid,
    input wire logic [31:0]  issue_instr,
    input wire logic [W-1:0] src_data,
    input wire logic         wb_valid,
    input wire logic [4:0]   wb_index,
    input wire logic [W-1:0] wb_data,
    input wire logic         signed_wrap_flag,
    input wire logic         sticky_wrap_flag,
    input wire logic         add_out_bit,
    input wire logic [3:0]   cond_field0,
    input wire logic         bus_wr
);
    // ****************************************
    // Decode of the watched instruction
    // ****************************************
    wire [5:0]  op  = issue_instr[31:26];
    wire [8:0]  xo  = issue_instr[9:1];
    wire        go  = issue_valid && !bus_wr;
    wire        up  = go && op == 6'h0f;
    wire        ext = go && op == 6'h1f && (xo == 9'h0ea || xo == 9'h0ca);
    wire        rec = go && (op == 6'h0d || ext && issue_instr[0]);
    wire [4:0]  dst = issue_instr[25:21];
    wire [31:0] s32 = src_data[31:0] + {issue_instr[15:0], 16'h0000};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_up_sum;
        up && issue_instr[20:16] != 5'h00 |=>
            wb_valid && wb_index == $past(dst) && wb_data[31:0] == $past(s32);
    endproperty
    a_up_sum: assert property (p_up_sum) else $error("upper add sum");
    property p_up_zero;
        up && issue_instr[20:16] == 5'h00 |=> wb_data[31:16] == $past(issue_instr[15:0]) && wb_data[15:0] == 16'h0000;
    endproperty
    a_up_zero: assert property (p_up_zero) else $error("reg zero");
    property p_up_ext;
        up |=> wb_data[63:32] == 32'h0 || wb_data[63:32] == {32{wb_data[31]}};
    endproperty
    a_up_ext: assert property (p_up_ext) else $error("upper half");
    property p_up_keep;
        up |=> $stable(add_out_bit) && $stable(signed_wrap_flag) && $stable(sticky_wrap_flag) && $stable(cond_field0);
    endproperty
    a_up_keep: assert property (p_up_keep) else $error("flags moved");
    property p_oe_keep;
        ext && !issue_instr[10] |=> $stable(signed_wrap_flag) && $stable(sticky_wrap_flag);
    endproperty
    a_oe_keep: assert property (p_oe_keep) else $error("wrap moved");
    property p_rc_keep;
        ext && !issue_instr[0] |=> $stable(cond_field0);
    endproperty
    a_rc_keep: assert property (p_rc_keep) else $error("field moved");
    property p_one_hot;
        rec |=> $onehot(cond_field0[3:1]);
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("not one hot");
    property p_summary;
        rec |=> cond_field0[0] == sticky_wrap_flag;
    endproperty
    a_summary: assert property (p_summary) else $error("summary copy");
    property p_sticky;
        $rose(signed_wrap_flag) && !$past(bus_wr) |-> sticky_wrap_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky not set");
    property p_wb_cause;
        wb_valid |-> $past(issue_valid);
    endproperty
    a_wb_cause: assert property (p_wb_cause) else $error("stray write");

    c_up: cover property (up ##1 wb_valid);
    c_wrap: cover property (ext ##1 signed_wrap_flag);
    c_rec: cover property (rec ##1 cond_field0[1]);
endmodule // fpa_add_unit_monitor

bind fpa_add_unit fpa_add_unit_monitor #(.W(W)) fpa_add_unit_monitor_inst (
    .clk(clk),
    .arst_n(arst_n),
    .issue_valid(issue_valid),
    .issue_instr(issue_instr),
    .src_data(src_data),
    .wb_valid(wb_valid),
    .wb_index(wb_index),
    .wb_data(wb_data),
    .signed_wrap_flag(signed_wrap_flag),
    .sticky_wrap_flag(sticky_wrap_flag),
    .add_out_bit(add_out_bit),
    .cond_field0(cond_field0),
    .bus_wr(bus_wr)
);
`default_nettype wire

//--- fpa_regfile_model.sv
// General register file model facing the add datapath.
// Assumes a combinational read and a write at the rising clock edge while wb_valid is high.
`timescale 1ns/1ns
`default_nettype none

module fpa_regfile_model #(
    parameter W = 64
) (
    input  wire logic         clk,
    input  wire logic [4:0]   src_index,
    output logic      [W-1:0] src_data,
    input  wire logic         wb_valid,
    input  wire logic [4:0]   wb_index,
    input  wire logic [W-1:0] wb_data
);
    logic [W-1:0] regs [0:31];

    assign src_data = regs[src_index];

    always @(posedge clk) begin
        if (wb_valid) begin
            regs[wb_index] <= wb_data;
        end
    end
endmodule // fpa_regfile_model
`default_nettype wire

//--- fpa_add_unit_tb_top.sv
// Self-checking bench of the fixed-point add datapath.
// Assumes the register file model and the bound checker.
`timescale 1ns/1ns
`default_nettype none

module fpa_add_unit_tb_top;
    logic        clk;
    logic        arst_n;
    logic        issue_valid;
    logic [31:0] issue_instr;
    logic [4:0]  src_index;
    logic [63:0] src_data;
    logic        wb_valid;
    logic [4:0]  wb_index;
    logic [63:0] wb_data;
    logic        add_out_bit;
    logic        signed_wrap_flag;
    logic        sticky_wrap_flag;
    logic [3:0]  cond_field0;
    logic        irq;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic [31:0] bus_rdata;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    wire  [6:0]  fl = {add_out_bit, signed_wrap_flag, sticky_wrap_flag,
                       cond_field0};

    fpa_add_unit fpa_add_unit_inst (.clk(clk), .arst_n(arst_n),
        .issue_valid(issue_valid), .issue_instr(issue_instr),
        .src_index(src_index), .src_data(src_data), .wb_valid(wb_valid),
        .wb_index(wb_index), .wb_data(wb_data), .add_out_bit(add_out_bit),
        .signed_wrap_flag(signed_wrap_flag),
        .sticky_wrap_flag(sticky_wrap_flag), .cond_field0(cond_field0),
        .irq(irq), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
    fpa_regfile_model fpa_regfile_model_inst (.clk(clk),
        .src_index(src_index), .src_data(src_data), .wb_valid(wb_valid),
        .wb_index(wb_index), .wb_data(wb_data));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask
    task automatic bus_read(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, e);
    endtask
    task automatic run(input logic [31:0] i, input logic v,
                       input logic [63:0] e);
        @(posedge clk);
        issue_valid <= 1'b1;
        issue_instr <= i;
        @(posedge clk);
        issue_valid <= 1'b0;
        #1 chk({wb_valid, wb_index}, {v, (v ? i[25:21] : wb_index)});
        if (v) chk(wb_data, e);
    endtask
    function automatic logic [31:0] xi(input logic [4:0] d, s,
                                       input logic oe, input logic [8:0] xo,
                                       input logic rc);
        return {6'h1f, d, s, 5'h00, oe, xo, rc};
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_upper;
        fpa_regfile_model_inst.regs[6] = 64'h4000;
        fpa_regfile_model_inst.regs[0] = 64'h55;
        bus_read(8'h04, 32'h1);
        bus_read(8'hfc, 32'h0);
        bus_write(8'h00, 32'h1);
        run({6'h0f, 5'd7, 5'd6, 16'h0011}, 1'b1, 64'h11_4000);
        run({6'h0f, 5'd8, 5'd0, 16'h8000}, 1'b1, 64'hffff_ffff_8000_0000);
        run({6'h0f, 5'd9, 5'd7, 16'h7fff}, 1'b1, 64'hffff_ffff_8010_4000);
        chk(fl, 7'h40);
        $display("upper test done");
    endtask
    task automatic t_minus_one;
        fpa_regfile_model_inst.regs[4] = 64'h9000_3000;
        fpa_regfile_model_inst.regs[5] = 64'h8000_0000;
        bus_write(8'h04, 32'h0);
        bus_write(8'h00, 32'h0);
        run(xi(5'd6, 5'd4, 1'b0, 9'h0ea, 1'b0), 1'b1, 64'h9000_2fff);
        chk(fl, 7'h40);
        bus_write(8'h00, 32'h0);
        run(xi(5'd6, 5'd5, 1'b1, 9'h0ea, 1'b1), 1'b1, 64'h7fff_ffff);
        chk(fl, 7'h75);
        $display("minus one test done");
    endtask
    task automatic t_zero;
        fpa_regfile_model_inst.regs[4] = 64'hefff_ffff;
        run(xi(5'd6, 5'd4, 1'b0, 9'h0ca, 1'b1), 1'b1, 64'hf000_0000);
        chk(fl, 7'h39);
        run(xi(5'd6, 5'd4, 1'b1, 9'h0ca, 1'b0), 1'b1, 64'hefff_ffff);
        chk(fl, 7'h19);
        $display("zero test done");
    endtask
    task automatic t_imm_rec;
        fpa_regfile_model_inst.regs[3] = 64'h1;
        run({6'h0d, 5'd2, 5'd3, 16'hffff}, 1'b1, 64'h0);
        chk(fl, 7'h53);
        run({6'h0d, 5'd2, 5'd4, 16'h1000}, 1'b1, 64'hf000_0fff);
        chk(fl, 7'h19);
        $display("record test done");
    endtask
    task automatic t_events;
        run(32'h0000_0000, 1'b0, 64'h0);
        chk(fl, 7'h19);
        bus_read(8'h08, 32'hf);
        chk(irq, 1'b0);
        bus_write(8'h0c, 32'h4);
        chk(irq, 1'b1);
        bus_write(8'h08, 32'h4);
        chk(irq, 1'b0);
        bus_read(8'h08, 32'hb);
        bus_write(8'hfc, 32'hff);
        bus_read(8'h0c, 32'h4);
        bus_read(8'h10, 32'hf000_0fff);
        bus_read(8'h14, 32'h0);
        bus_write(8'h00, 32'h0);
        chk(fl, 7'h00);
        $display("event test done");
    endtask

    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            test_done;
        end
    end
    initial begin
        arst_n = 1'b0;
        issue_valid = 1'b0;
        issue_instr = 32'h0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        #1 chk({irq, fl}, 8'h00);
        t_upper;
        t_minus_one;
        t_zero;
        t_imm_rec;
        t_events;
        test_done;
    end
endmodule // fpa_add_unit_tb_top
`default_nettype wire
